// ---- rtl/cac_pkg.sv ----
package cac_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] CAC_ADDR_CTRL  = 8'hD8;
    localparam logic [7:0] CAC_ADDR_MODE  = 8'hD9;
    localparam logic [7:0] CAC_ADDR_CNT_L = 8'hF9;
    localparam logic [7:0] CAC_ADDR_CNT_H = 8'hFA;
    // Index n of each array is module n
    localparam logic [4:0][7:0] CAC_ADDR_MMODE = {8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
    localparam logic [4:0][7:0] CAC_ADDR_CMP_L = {8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
    localparam logic [4:0][7:0] CAC_ADDR_CMP_H = {8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};

    // ==========================================================
    // Field positions
    localparam int CAC_CTRL_CF   = 7;
    localparam int CAC_CTRL_CR   = 6;
    localparam int CAC_MD_IDLE   = 7;
    localparam int CAC_MD_WATCHDOG_ENABLE   = 6;
    localparam int CAC_MD_LOCK   = 5;
    localparam int CAC_MD_TB_LO  = 1;
    localparam int CAC_MD_ECF    = 0;
    localparam int CAC_NUM_MOD   = 5;
    localparam int CAC_WD_MOD    = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CAC_CTRL_RST = 8'h00;
    localparam logic [7:0] CAC_MODE_RST = 8'h40;
    localparam logic [7:0] CAC_MMOD_RST = 8'h00;
    localparam logic [15:0] CAC_CNT_RST = 16'h0000;

    // ==========================================================
    // Timebase codes and prescale counts
    localparam logic [2:0] CAC_TB_DIV12 = 3'h0;
    localparam logic [2:0] CAC_TB_DIV4  = 3'h1;
    localparam logic [2:0] CAC_TB_T0OV  = 3'h2;
    localparam logic [2:0] CAC_TB_ECI   = 3'h3;
    localparam logic [2:0] CAC_TB_SYS   = 3'h4;
    localparam logic [2:0] CAC_TB_OSC8  = 3'h5;
    localparam logic [3:0] CAC_PRE_LAST = 4'hB;
    localparam logic [1:0] CAC_DIV4_LAST = 2'h3;

    // ==========================================================
    // Module mode layout
    typedef struct packed {
        logic wide;
        logic cmp_en;
        logic rise_cap;
        logic fall_cap;
        logic match_en;
        logic toggle_en;
        logic mod_en;
        logic flag_irq_en;
    } cac_mmode_t;

endpackage

// ---- rtl/cac_counter_array.sv ----
`timescale 1ns/100ps
// What this block does
// - Overflow flag sets when the shared counter wraps from FFFF to 0000.
// - Hardware never clears flags; software clears them by writing zero.
// - Interrupt request rises while overflow flag and its enable are both one.
// - Shared counter advances only while run control or the watchdog enable is one.
// - Each module's flag, bits 0 to 4, sets on its match or capture, except module 4 under watchdog.
// - Interrupt request rises while a module flag and its enable are one.
// - Control bit 5 and mode bit 4 read zero and ignore writes.
// - With idle suspend set, the counter halts while the processor idles.
// - Watchdog enable makes module 4 the watchdog; clear disables it.
// - Lock bit enables the watchdog; disabling refused until system reset.
// - Timebase field picks sysclk/12, /4, timer0, external falls, sysclk, osc/8.
// - External input counts falling edges; source stays below sysclk/4.
// - Oscillator divided-by-8 timebase is synchronised before counting.
// - While the watchdog is enabled, mode register writes change only the watchdog enable and lock bits.
// - Wide select chooses 16-bit modulation, else 8-bit.
// - A module's comparator works only while its compare enable is one.
// - Capture on rising pin edge or falling edge per the two enables.
// - Match enable sets the module flag when counter equals compare value.
// - Toggle enable inverts the output pin when counter equals compare value.
// - Toggle plus modulation enable gives frequency output mode.
// - Modulation enable drives a pulse width waveform on the output pin.
// - Counter readable as low and high byte registers; writable only while the watchdog is disabled.
// - Compare low write clears compare enable; high write sets it, except on module 4 under watchdog.
// - Watchdog resets when low byte overflows while module 4 high matches.
// - Watchdog high write loads counter high plus module 4 low offset.
// - Writing one to module 4 flag under watchdog forces reset.
module cac_counter_array (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        cpu_idle,
    input  wire logic        timer0_ovf,
    input  wire logic        external_count_input,
    input  wire logic        ext_osc_div8,
    input  wire logic [4:0]  module_pin_in,
    output logic      [4:0]  module_output_pin,
    output logic             irq,
    output logic             wdt_reset
);

    // ==========================================================
    // Registers
    logic [7:0]              rdata_ff;
    logic                    cf_ff;
    logic                    run_ff;
    logic [4:0]              mflag_ff;
    logic                    idle_ff;
    logic                    watchdog_enable_ff;
    logic                    lock_ff;
    logic [2:0]              tb_ff;
    logic                    ecf_ff;
    logic [15:0]             cnt_ff;
    logic [3:0]              pre_ff;
    logic                    eci_prev_ff;
    logic [2:0]              osc_sync_ff;
    logic [4:0]              pin_prev_ff;
    logic [4:0]              pin_ff;
    logic                    irq_ff;
    logic                    wdt_rst_ff;
    cac_pkg::cac_mmode_t     mmode_ff [5];
    logic [15:0]             cmp_ff   [5];

    logic                    wdt_en;
    logic                    src_pulse;
    logic                    tick;
    logic [15:0]             cnt_inc;
    logic                    low_ovf;
    logic                    full_ovf;
    logic                    wr_ctrl;
    logic                    wr_mode;
    logic [4:0]              mflag_set;
    logic [7:0]              nxt_rdata;

    assign wdt_en   = watchdog_enable_ff | lock_ff;
    assign wr_ctrl  = sfr_wr && (sfr_addr == cac_pkg::CAC_ADDR_CTRL);
    assign wr_mode  = sfr_wr && (sfr_addr == cac_pkg::CAC_ADDR_MODE);
    assign cnt_inc  = 16'(cnt_ff + 16'h0001);
    assign low_ovf  = tick && (cnt_ff[7:0] == 8'hFF);
    assign full_ovf = tick && (cnt_ff == 16'hFFFF);

    // ==========================================================
    // Timebase
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pre_ff <= 4'h0;
        else if (pre_ff == cac_pkg::CAC_PRE_LAST)
            pre_ff <= 4'h0;
        else
            pre_ff <= 4'(pre_ff + 4'h1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            eci_prev_ff <= 1'b0;
            osc_sync_ff <= 3'h0;
            pin_prev_ff <= 5'h00;
        end
        else
        begin
            eci_prev_ff <= external_count_input;
            osc_sync_ff <= {osc_sync_ff[1:0], ext_osc_div8};
            pin_prev_ff <= module_pin_in;
        end
    end

    always_comb
    begin
        case (tb_ff)
            cac_pkg::CAC_TB_DIV12: src_pulse = (pre_ff == cac_pkg::CAC_PRE_LAST);
            cac_pkg::CAC_TB_DIV4:  src_pulse = (pre_ff[1:0] == cac_pkg::CAC_DIV4_LAST);
            cac_pkg::CAC_TB_T0OV:  src_pulse = timer0_ovf;
            cac_pkg::CAC_TB_ECI:   src_pulse = eci_prev_ff & ~external_count_input;
            cac_pkg::CAC_TB_SYS:   src_pulse = 1'b1;
            cac_pkg::CAC_TB_OSC8:  src_pulse = osc_sync_ff[1] & ~osc_sync_ff[2];
            default:               src_pulse = 1'b0;
        endcase
    end

    // Watchdog forces the counter on; idle suspend overrides everything
    assign tick = src_pulse && (run_ff || wdt_en) && !(idle_ff && cpu_idle);

    // ==========================================================
    // Shared counter
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cnt_ff <= cac_pkg::CAC_CNT_RST;
        else if (sfr_wr && !wdt_en && sfr_addr == cac_pkg::CAC_ADDR_CNT_L)
            cnt_ff[7:0] <= sfr_wdata;
        else if (sfr_wr && !wdt_en && sfr_addr == cac_pkg::CAC_ADDR_CNT_H)
            cnt_ff[15:8] <= sfr_wdata;
        else if (tick)
            cnt_ff <= cnt_inc;
    end

    // ==========================================================
    // Control register; a hardware set wins over a software clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cf_ff    <= cac_pkg::CAC_CTRL_RST[cac_pkg::CAC_CTRL_CF];
            run_ff   <= cac_pkg::CAC_CTRL_RST[cac_pkg::CAC_CTRL_CR];
            mflag_ff <= cac_pkg::CAC_CTRL_RST[4:0];
        end
        else
        begin
            cf_ff    <= (wr_ctrl ? sfr_wdata[cac_pkg::CAC_CTRL_CF] : cf_ff) | full_ovf;
            mflag_ff <= (wr_ctrl ? sfr_wdata[4:0] : mflag_ff) | mflag_set;
            if (wr_ctrl)
                run_ff <= sfr_wdata[cac_pkg::CAC_CTRL_CR];
        end
    end

    // ==========================================================
    // Mode register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            idle_ff <= cac_pkg::CAC_MODE_RST[cac_pkg::CAC_MD_IDLE];
            watchdog_enable_ff <= cac_pkg::CAC_MODE_RST[cac_pkg::CAC_MD_WATCHDOG_ENABLE];
            lock_ff <= cac_pkg::CAC_MODE_RST[cac_pkg::CAC_MD_LOCK];
            tb_ff   <= cac_pkg::CAC_MODE_RST[cac_pkg::CAC_MD_TB_LO +: 3];
            ecf_ff  <= cac_pkg::CAC_MODE_RST[cac_pkg::CAC_MD_ECF];
        end
        else if (wr_mode && wdt_en)
        begin
            // Only the watchdog enable and lock bits move while the watchdog runs
            watchdog_enable_ff <= sfr_wdata[cac_pkg::CAC_MD_WATCHDOG_ENABLE] | lock_ff;
            lock_ff <= lock_ff | sfr_wdata[cac_pkg::CAC_MD_LOCK];
        end
        else if (wr_mode)
        begin
            idle_ff <= sfr_wdata[cac_pkg::CAC_MD_IDLE];
            watchdog_enable_ff <= sfr_wdata[cac_pkg::CAC_MD_WATCHDOG_ENABLE] | sfr_wdata[cac_pkg::CAC_MD_LOCK];
            lock_ff <= sfr_wdata[cac_pkg::CAC_MD_LOCK];
            tb_ff   <= sfr_wdata[cac_pkg::CAC_MD_TB_LO +: 3];
            ecf_ff  <= sfr_wdata[cac_pkg::CAC_MD_ECF];
        end
    end

    // ==========================================================
    // Capture/compare modules
    for (genvar i = 0; i < cac_pkg::CAC_NUM_MOD; i++)
    begin : g_mod
        logic wd_mod;
        logic match16;
        logic match8;
        logic cap_evt;
        logic wr_mm;
        logic wr_lo;
        logic wr_hi;

        assign wd_mod  = (i == cac_pkg::CAC_WD_MOD) && wdt_en;
        assign wr_mm   = sfr_wr && (sfr_addr == cac_pkg::CAC_ADDR_MMODE[i]);
        assign wr_lo   = sfr_wr && (sfr_addr == cac_pkg::CAC_ADDR_CMP_L[i]);
        assign wr_hi   = sfr_wr && (sfr_addr == cac_pkg::CAC_ADDR_CMP_H[i]);
        assign match16 = tick && mmode_ff[i].cmp_en && (cnt_inc == cmp_ff[i]);
        assign match8  = tick && mmode_ff[i].cmp_en && (cnt_inc[7:0] == cmp_ff[i][7:0]);
        assign cap_evt = !wd_mod && ((mmode_ff[i].rise_cap && module_pin_in[i] && !pin_prev_ff[i])
                         || (mmode_ff[i].fall_cap && !module_pin_in[i] && pin_prev_ff[i]));
        assign mflag_set[i] = !wd_mod && (cap_evt || (mmode_ff[i].match_en &&
                              ((mmode_ff[i].mod_en && !mmode_ff[i].wide) ? match8 : match16)));

        always_ff @(posedge clk)
        begin
            if (!rst_b)
            begin
                mmode_ff[i] <= cac_pkg::CAC_MMOD_RST;
                cmp_ff[i]   <= 16'h0000;
            end
            else
            begin
                if (wr_mm && !(i == cac_pkg::CAC_WD_MOD && wdt_en))
                    mmode_ff[i] <= sfr_wdata;
                if (wr_lo)
                begin
                    cmp_ff[i][7:0]     <= sfr_wdata;
                    mmode_ff[i].cmp_en <= wd_mod & mmode_ff[i].cmp_en;
                end
                if (wr_hi && wd_mod)
                    cmp_ff[i][15:8] <= 8'(cnt_ff[15:8] + cmp_ff[i][7:0]);
                else if (wr_hi)
                begin
                    cmp_ff[i][15:8]    <= sfr_wdata;
                    mmode_ff[i].cmp_en <= 1'b1;
                end
                if (!wd_mod && mmode_ff[i].mod_en && mmode_ff[i].toggle_en && match8)
                    cmp_ff[i][7:0] <= 8'(cmp_ff[i][7:0] + cmp_ff[i][15:8]);
                else if (!wd_mod && mmode_ff[i].mod_en && !mmode_ff[i].wide && low_ovf)
                    cmp_ff[i][7:0] <= cmp_ff[i][15:8];
                if (cap_evt)
                    cmp_ff[i] <= cnt_ff;
            end
        end

        always_ff @(posedge clk)
        begin
            if (!rst_b)
                pin_ff[i] <= 1'b0;
            else if (wd_mod)
                pin_ff[i] <= 1'b0;
            else if (mmode_ff[i].mod_en && mmode_ff[i].toggle_en)
                pin_ff[i] <= pin_ff[i] ^ match8;
            else if (mmode_ff[i].mod_en && !mmode_ff[i].cmp_en)
                pin_ff[i] <= 1'b0;
            else if (mmode_ff[i].mod_en && mmode_ff[i].wide)
            begin
                if (match16)
                    pin_ff[i] <= 1'b1;
                else if (full_ovf)
                    pin_ff[i] <= 1'b0;
            end
            else if (mmode_ff[i].mod_en)
            begin
                if (match8)
                    pin_ff[i] <= 1'b1;
                else if (low_ovf)
                    pin_ff[i] <= 1'b0;
            end
            else if (mmode_ff[i].toggle_en && match16)
                pin_ff[i] <= ~pin_ff[i];
        end
    end

    // ==========================================================
    // Interrupt and watchdog reset
    logic [4:0] mflag_irq;
    for (genvar j = 0; j < cac_pkg::CAC_NUM_MOD; j++)
    begin : g_irq
        assign mflag_irq[j] = mflag_ff[j] & mmode_ff[j].flag_irq_en;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_ff     <= 1'b0;
            wdt_rst_ff <= 1'b0;
        end
        else
        begin
            irq_ff     <= (cf_ff & ecf_ff) | (|mflag_irq);
            wdt_rst_ff <= wdt_en && ((low_ovf && cmp_ff[cac_pkg::CAC_WD_MOD][15:8] == cnt_ff[15:8])
                          || (wr_ctrl && sfr_wdata[cac_pkg::CAC_WD_MOD]));
        end
    end

    // ==========================================================
    // Read data
    always_comb
    begin
        nxt_rdata = 8'h00;
        case (sfr_addr)
            cac_pkg::CAC_ADDR_CTRL:  nxt_rdata = {cf_ff, run_ff, 1'b0, mflag_ff};
            cac_pkg::CAC_ADDR_MODE:  nxt_rdata = {idle_ff, watchdog_enable_ff, lock_ff, 1'b0, tb_ff, ecf_ff};
            cac_pkg::CAC_ADDR_CNT_L: nxt_rdata = cnt_ff[7:0];
            cac_pkg::CAC_ADDR_CNT_H: nxt_rdata = cnt_ff[15:8];
            default:                 nxt_rdata = 8'h00;
        endcase
        for (int k = 0; k < cac_pkg::CAC_NUM_MOD; k++)
        begin
            if (sfr_addr == cac_pkg::CAC_ADDR_MMODE[k])
                nxt_rdata = mmode_ff[k];
            if (sfr_addr == cac_pkg::CAC_ADDR_CMP_L[k])
                nxt_rdata = cmp_ff[k][7:0];
            if (sfr_addr == cac_pkg::CAC_ADDR_CMP_H[k])
                nxt_rdata = cmp_ff[k][15:8];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rdata_ff <= 8'h00;
        else if (sfr_rd)
            rdata_ff <= nxt_rdata;
    end

    assign sfr_rdata         = rdata_ff;
    assign module_output_pin = pin_ff;
    assign irq               = irq_ff;
    assign wdt_reset         = wdt_rst_ff;

    // ==========================================================
    // Checks
    a_ovf_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
        full_ovf |=> cf_ff) else $error("overflow flag not set on wrap");
    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
        (cf_ff && !wr_ctrl) |=> cf_ff) else $error("overflow flag cleared by hardware");
    a_irq_ovf: assert property (@(posedge clk) disable iff (!rst_b)
        (cf_ff && ecf_ff) |=> irq) else $error("overflow interrupt missing");
    a_cnt_stopped: assert property (@(posedge clk) disable iff (!rst_b)
        (!run_ff && !wdt_en && !sfr_wr) |=> $stable(cnt_ff)) else $error("counter moved while stopped");
    a_unused_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == cac_pkg::CAC_ADDR_CTRL) |=> !sfr_rdata[5])
        else $error("unused control bit read nonzero");
    a_lock_holds: assert property (@(posedge clk) disable iff (!rst_b)
        lock_ff |=> (watchdog_enable_ff && lock_ff)) else $error("locked watchdog disabled");
    a_wd_mode_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        wdt_en |=> $stable(mmode_ff[cac_pkg::CAC_WD_MOD])) else $error("watchdog mode changed");
    a_force_reset: assert property (@(posedge clk) disable iff (!rst_b)
        (wdt_en && wr_ctrl && sfr_wdata[cac_pkg::CAC_WD_MOD]) |=> wdt_reset)
        else $error("forced watchdog reset missing");

endmodule

// ---- test/cac_counter_array_tb.sv ----
`timescale 1ns/100ps
module cac_counter_array_tb;

    // ==========================================================
    // Stimulus and observed signals
    logic        clk                  = 1'h0;
    logic        rst_b                = 1'h0;
    logic [7:0]  sfr_addr             = 8'h00;
    logic        sfr_wr               = 1'h0;
    logic        sfr_rd               = 1'h0;
    logic [7:0]  sfr_wdata            = 8'h00;
    logic [7:0]  sfr_rdata;
    logic        cpu_idle             = 1'h0;
    logic        timer0_ovf           = 1'h0;
    logic        external_count_input = 1'h0;
    logic        ext_osc_div8         = 1'h0;
    logic [4:0]  module_pin_in        = 5'h00;
    logic [4:0]  module_output_pin;
    logic        irq;
    logic        wdt_reset;
    int          failures             = 0;
    int          cmp_count            = 0;
    int          wdt_pulses           = 0;
    int          seed                 = 32'h2105FD6C;
    int          divs[8]              = '{12, 4, 3, 8, 1, 8, 0, 0};
    int          p0;
    int          ex;
    logic [7:0]  rv;
    logic [7:0]  hv;
    logic [15:0] rnd16;
    logic [39:0] pv;
    logic [31:0] pmodes               = 32'h46C24244;

    always #5 clk = ~clk;

    cac_counter_array dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .sfr_addr             (sfr_addr),
        .sfr_wr               (sfr_wr),
        .sfr_rd               (sfr_rd),
        .sfr_wdata            (sfr_wdata),
        .sfr_rdata            (sfr_rdata),
        .cpu_idle             (cpu_idle),
        .timer0_ovf           (timer0_ovf),
        .external_count_input (external_count_input),
        .ext_osc_div8         (ext_osc_div8),
        .module_pin_in        (module_pin_in),
        .module_output_pin    (module_output_pin),
        .irq                  (irq),
        .wdt_reset            (wdt_reset)
    );

    always @(posedge clk)
    begin
        if (wdt_reset === 1'h1)
        begin
            wdt_pulses <= wdt_pulses + 1;
        end
    end

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Gives the expected value inside the window, else the raw value so that it mismatches
    function automatic logic [15:0] in_range(input logic [15:0] got, input int exp);
        int lo;
        int hi;
        lo = (exp == 0) ? 0 : exp - 2;
        hi = (exp == 0) ? 0 : exp + 3;
        return (got >= lo && got <= hi) ? 16'(exp) : got;
    endfunction

    // Expected output pins once the counter has run from zero to c without a wrap
    function automatic logic [4:0] pin_exp(input logic [7:0] c, input logic [39:0] v);
        int hits;
        hits = (c >= v[31:24]) ? int'(c - v[31:24]) / int'(v[39:32]) + 1 : 0;
        return {1'b0, hits[0], 1'b0, c >= v[15:8], c >= v[7:0]};
    endfunction

    task automatic give_verdict();
        $display("comparisons=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_b = 1'h0;
        repeat (12) @(negedge clk);
        rst_b = 1'h1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clk);
        sfr_wr = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'h1;
        @(negedge clk);
        sfr_rd = 1'h0;
        @(negedge clk);
        d = sfr_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // Runs the counter from zero for 96 cycles with every timebase source active
    task automatic window(input logic [7:0] mode, input logic idle, output logic [7:0] cnt);
        wr(cac_pkg::CAC_ADDR_MODE, mode);
        wr(cac_pkg::CAC_ADDR_CNT_L, 8'h00);
        wr(cac_pkg::CAC_ADDR_CNT_H, 8'h00);
        cpu_idle = idle;
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h40);
        for (int i = 0; i < 96; i++)
        begin
            @(negedge clk);
            timer0_ovf = (i % 3 == 0);
            external_count_input = ((i / 4) % 2 == 1);
            ext_osc_div8 = ((i / 4) % 2 == 1);
        end
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        cpu_idle = 1'h0;
        timer0_ovf = 1'h0;
        external_count_input = 1'h0;
        ext_osc_div8 = 1'h0;
        rd(cac_pkg::CAC_ADDR_CNT_L, cnt);
    endtask

    // ==========================================================
    // Watchdog for hangs
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(negedge clk);
        chk({sfr_rdata, 1'h0, module_output_pin, irq, wdt_reset}, 16'h0000);
        repeat (9) @(negedge clk);
        rst_b = 1'h1;
        rd(cac_pkg::CAC_ADDR_CNT_L, rv);
        chk(in_range({8'h00, rv}, 0), 16'h0000);
        rchk(cac_pkg::CAC_ADDR_CNT_H, 8'h00);
        rchk(cac_pkg::CAC_ADDR_CTRL, cac_pkg::CAC_CTRL_RST);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h40);
        for (int n = 0; n < 5; n++)
        begin
            rchk(cac_pkg::CAC_ADDR_MMODE[n], 8'h00);
        end
        rchk(8'h80, 8'h00);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h00);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h00);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h10);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h00);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h20);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        rnd16 = 16'($random(seed));
        wr(cac_pkg::CAC_ADDR_CNT_L, rnd16[7:0]);
        wr(cac_pkg::CAC_ADDR_CNT_H, rnd16[15:8]);
        repeat (20) @(negedge clk);
        rchk(cac_pkg::CAC_ADDR_CNT_L, rnd16[7:0]);
        rchk(cac_pkg::CAC_ADDR_CNT_H, rnd16[15:8]);
        for (int c = 0; c < 8; c++)
        begin
            window({4'h0, 3'(c), 1'h0}, 1'h0, rv);
            ex = (divs[c] == 0) ? 0 : 96 / divs[c];
            chk(in_range({8'h00, rv}, ex), 16'(ex));
            repeat (20) @(negedge clk);
            rchk(cac_pkg::CAC_ADDR_CNT_L, rv);
        end
        window(8'h88, 1'h1, rv);
        chk({8'h00, rv}, 16'h0000);
        window(8'h08, 1'h1, rv);
        chk(in_range({8'h00, rv}, 96), 16'd96);
        wr(cac_pkg::CAC_ADDR_CNT_L, 8'hFC);
        wr(cac_pkg::CAC_ADDR_CNT_H, 8'hFF);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h40);
        repeat (10) @(negedge clk);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'hC0);
        chk({15'h0000, irq}, 16'h0000);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h09);
        repeat (2) @(negedge clk);
        chk({15'h0000, irq}, 16'h0001);
        repeat (20) @(negedge clk);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'hC0);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h08);
        wr(cac_pkg::CAC_ADDR_CNT_L, 8'h00);
        wr(cac_pkg::CAC_ADDR_CNT_H, 8'h00);
        for (int n = 0; n < 5; n++)
        begin
            wr(cac_pkg::CAC_ADDR_CMP_L[n], 8'h10 + 8'($random(seed) & 31));
            wr(cac_pkg::CAC_ADDR_CMP_H[n], 8'h00);
            wr(cac_pkg::CAC_ADDR_MMODE[n], (n % 2 == 0) ? 8'h49 : 8'h09);
        end
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h40);
        repeat (100) @(negedge clk);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'h55);
        chk({15'h0000, irq}, 16'h0001);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        rnd16 = {1'h1, 15'($random(seed))};
        wr(cac_pkg::CAC_ADDR_CNT_L, rnd16[7:0]);
        wr(cac_pkg::CAC_ADDR_CNT_H, rnd16[15:8]);
        module_pin_in = 5'h06;
        wr(cac_pkg::CAC_ADDR_MMODE[0], 8'h20);
        wr(cac_pkg::CAC_ADDR_MMODE[1], 8'h10);
        wr(cac_pkg::CAC_ADDR_MMODE[2], 8'h20);
        @(negedge clk);
        module_pin_in = 5'h01;
        repeat (4) @(negedge clk);
        rchk(cac_pkg::CAC_ADDR_CTRL, 8'h03);
        rd(cac_pkg::CAC_ADDR_CMP_L[0], rv);
        rd(cac_pkg::CAC_ADDR_CMP_H[0], hv);
        chk({hv, rv}, rnd16);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        wr(cac_pkg::CAC_ADDR_CMP_L[4], 8'h00);
        wr(cac_pkg::CAC_ADDR_CMP_H[4], 8'h00);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h28);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h68);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h00);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h68);
        wr(cac_pkg::CAC_ADDR_MMODE[4], 8'hFF);
        rchk(cac_pkg::CAC_ADDR_MMODE[4], 8'h49);
        p0 = wdt_pulses;
        wr(cac_pkg::CAC_ADDR_CMP_H[4], 8'hAA);
        repeat (270) @(negedge clk);
        chk(16'(wdt_pulses - p0), 16'h0001);
        p0 = wdt_pulses;
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h10);
        repeat (2) @(negedge clk);
        chk(16'(wdt_pulses - p0), 16'h0001);
        do_reset();
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h40);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h00);
        rchk(cac_pkg::CAC_ADDR_MODE, 8'h00);
        wr(cac_pkg::CAC_ADDR_MODE, 8'h08);
        wr(cac_pkg::CAC_ADDR_CMP_H[4], 8'h00);
        rchk(cac_pkg::CAC_ADDR_MMODE[4], 8'h40);
        wr(cac_pkg::CAC_ADDR_CMP_L[4], 8'h00);
        rchk(cac_pkg::CAC_ADDR_MMODE[4], 8'h00);
        wr(cac_pkg::CAC_ADDR_CNT_L, 8'h00);
        wr(cac_pkg::CAC_ADDR_CNT_H, 8'h00);
        pv = {8'($random(seed)), 32'($random(seed))} | 40'h0101010101;
        pv[39:32] = {4'h0, pv[35:32]};
        for (int n = 0; n < 4; n++)
        begin
            wr(cac_pkg::CAC_ADDR_CMP_L[n], pv[n * 8 +: 8]);
            wr(cac_pkg::CAC_ADDR_CMP_H[n], (n == 3) ? pv[39:32] : 8'(n / 2));
            wr(cac_pkg::CAC_ADDR_MMODE[n], pmodes[n * 8 +: 8]);
        end
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h40);
        repeat (150 + ($random(seed) & 63)) @(negedge clk);
        wr(cac_pkg::CAC_ADDR_CTRL, 8'h00);
        rd(cac_pkg::CAC_ADDR_CNT_L, rv);
        chk({11'h000, module_output_pin}, {11'h000, pin_exp(rv, pv)});
        give_verdict();
    end

endmodule
